/* design/dtpb_timer.sv */
`timescale 1ns/10ps

module dtpb_timer (
  // clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 sys_rst,
  // apb slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  input  wire logic [3:0]           pstrb,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  // instruction clock enable
  input  wire logic                 inst_tick,
  // shared pin
  input  wire logic                 shared_pin_i,
  output logic                      shared_pin_o,
  output logic                      shared_pin_oe,
  // gpio path when pin not claimed
  input  wire logic                 gpio_o,
  input  wire logic                 gpio_oe,
  // interrupt
  output logic                      irq
);

  ////////////////////////////////////////////////////////////////////////////
  dtpb_pkg::dtpb_ctrl1_t ctrl1_r;
  dtpb_pkg::dtpb_ctrl2_t ctrl2_r;
  logic [7:0]            count_r;
  logic [7:0]            reload_r;
  logic [7:0]            duty_r;
  logic [7:0]            pscnt_r;
  logic [7:0]            buzz_r;
  logic                  pwm_act_r;
  logic                  running_r;
  logic                  pin_d_r;
  logic                  buzz_div_r;
  logic [7:0]            buzz_cnt_r;
  logic                  stat_r;
  logic                  irq_en_r;
  logic                  ps_out_r;

  logic                  wr;
  logic                  rd_ok;
  logic [3:0]            idx;
  logic                  addr_ok;
  logic                  ext_event;
  logic                  src_event;
  logic                  ps_event;
  logic                  cnt_tick;
  logic                  underflow;
  logic [7:0]            ps_mask;
  logic                  pwm_lvl;
  logic                  buzz_lvl;

  assign idx     = paddr[5:2];
  assign addr_ok = (paddr[11:6] == 6'h00) && (paddr[1:0] == 2'h0)
                   && (idx <= dtpb_pkg::IDX_IRQ_EN);
  assign wr      = psel && penable && pwrite && addr_ok && pstrb[0];
  assign rd_ok   = psel && penable && !pwrite && addr_ok;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_ok;

  ////////////////////////////////////////////////////////////////////////////
  // clock source and edge
  // pin level held one cycle back to find edges; pin is taken as synchronous
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      // idle level of the pulled-up pin, so no false edge after reset
      pin_d_r <= 1'b1;
    end else begin
      pin_d_r <= shared_pin_i;
    end
  end

  always_comb begin
    if (ctrl2_r.edge_sel) begin
      ext_event = pin_d_r && !shared_pin_i;
    end else begin
      ext_event = !pin_d_r && shared_pin_i;
    end
  end

  assign src_event = ctrl2_r.source ? ext_event : inst_tick;

  ////////////////////////////////////////////////////////////////////////////
  // prescaler: free-running down counter, one tap per rate code
  // shift amount widened so code 7 does not wrap to a zero shift
  assign ps_mask = 8'(({1'b0, 8'h01} << ({1'b0, ctrl2_r.rate} + 4'd1))
                   - 9'd1);
  assign ps_event = src_event
                    && ((pscnt_r & ps_mask) == dtpb_pkg::CNT_ZERO);

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pscnt_r  <= dtpb_pkg::RST_PSCNT;
      ps_out_r <= 1'b0;
    end else if (ctrl2_r.ps_dis_n) begin
      pscnt_r <= dtpb_pkg::RST_PSCNT;
    end else if (src_event) begin
      pscnt_r <= pscnt_r - 8'h01;
      if (ps_event) begin
        ps_out_r <= !ps_out_r;
      end
    end
  end

  assign cnt_tick  = running_r && ctrl1_r.enable
                     && (ctrl2_r.ps_dis_n ? src_event : ps_event);
  assign underflow = cnt_tick && (count_r == dtpb_pkg::CNT_ZERO);

  ////////////////////////////////////////////////////////////////////////////
  // registers and counter
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ctrl1_r  <= dtpb_pkg::dtpb_ctrl1_t'(5'h00);
      ctrl2_r  <= dtpb_pkg::dtpb_ctrl2_t'(dtpb_pkg::RST_CTRL2);
      duty_r   <= dtpb_pkg::RST_DUTY;
      buzz_r   <= dtpb_pkg::RST_BUZZ;
      irq_en_r <= 1'b0;
    end else if (wr) begin
      unique case (idx)
        dtpb_pkg::IDX_CTRL1: begin
          ctrl1_r.enable   <= pwdata[dtpb_pkg::CTRL1_ENABLE];
          ctrl1_r.reload   <= pwdata[dtpb_pkg::CTRL1_RELOAD];
          ctrl1_r.one_shot <= pwdata[dtpb_pkg::CTRL1_ONE_SHOT];
          ctrl1_r.polarity <= pwdata[dtpb_pkg::CTRL1_POLARITY];
          ctrl1_r.pwm_oe   <= pwdata[dtpb_pkg::CTRL1_PWM_OE];
        end
        dtpb_pkg::IDX_CTRL2: begin
          ctrl2_r.rate     <= pwdata[dtpb_pkg::CTRL2_RATE_LSB +: 3];
          ctrl2_r.ps_dis_n <= pwdata[dtpb_pkg::CTRL2_PS_DIS_N];
          ctrl2_r.edge_sel <= pwdata[dtpb_pkg::CTRL2_EDGE];
          ctrl2_r.source   <= pwdata[dtpb_pkg::CTRL2_SOURCE];
        end
        dtpb_pkg::IDX_DUTY:   duty_r   <= pwdata[7:0];
        dtpb_pkg::IDX_BUZZ:   buzz_r   <= pwdata[7:0];
        dtpb_pkg::IDX_IRQ_EN: irq_en_r <= pwdata[0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      count_r   <= dtpb_pkg::RST_COUNT;
      reload_r  <= dtpb_pkg::RST_COUNT;
      running_r <= 1'b1;
    end else if (wr && idx == dtpb_pkg::IDX_COUNT) begin
      count_r   <= pwdata[7:0];
      reload_r  <= pwdata[7:0];
      running_r <= 1'b1;
    end else if (wr && idx == dtpb_pkg::IDX_CTRL1
                 && pwdata[dtpb_pkg::CTRL1_ENABLE] && !ctrl1_r.enable) begin
      running_r <= 1'b1; // re-arm a finished one-shot on enable
    end else if (underflow) begin
      if (ctrl1_r.one_shot) begin
        running_r <= 1'b0;
      end else if (ctrl1_r.reload) begin
        count_r <= reload_r;
      end else begin
        count_r <= dtpb_pkg::CNT_WRAP;
      end
    end else if (cnt_tick) begin
      count_r <= count_r - 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pwm
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pwm_act_r <= 1'b0;
    end else if (!ctrl1_r.enable || underflow) begin
      pwm_act_r <= 1'b0;
    end else if (running_r && count_r == duty_r) begin
      pwm_act_r <= 1'b1;
    end
  end

  assign pwm_lvl = pwm_act_r ^ ctrl1_r.polarity;

  ////////////////////////////////////////////////////////////////////////////
  // buzzer: tap by code either a further divide of prescaler output or, with code bit 3, the timer count
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      buzz_cnt_r <= 8'h00;
    end else if (ps_event && !ctrl2_r.ps_dis_n) begin
      buzz_cnt_r <= buzz_cnt_r + 8'h01;
    end
  end

  always_comb begin
    if (buzz_r[3]) begin
      buzz_lvl = count_r[buzz_r[2:0]];
    end else begin
      buzz_lvl = buzz_cnt_r[buzz_r[2:0]];
    end
  end

  // limitation: pwm has priority when both drive enables are set
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      shared_pin_o  <= 1'b0;
      shared_pin_oe <= 1'b0;
      buzz_div_r    <= 1'b0;
    end else begin
      buzz_div_r <= buzz_lvl;
      if (ctrl2_r.source) begin
        shared_pin_o  <= 1'b0;
        shared_pin_oe <= 1'b0;
      end else if (ctrl1_r.pwm_oe) begin
        shared_pin_o  <= pwm_lvl;
        shared_pin_oe <= 1'b1;
      end else if (buzz_r[dtpb_pkg::BUZZ_ENABLE]) begin
        shared_pin_o  <= buzz_lvl;
        shared_pin_oe <= 1'b1;
      end else begin
        shared_pin_o  <= gpio_o;
        shared_pin_oe <= gpio_oe;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt; set wins over clear
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      stat_r <= 1'b0;
    end else if (underflow) begin
      stat_r <= 1'b1;
    end else if (wr && idx == dtpb_pkg::IDX_IRQ_CLR && pwdata[0]) begin
      stat_r <= 1'b0;
    end
  end

  assign irq = stat_r && irq_en_r;

  ////////////////////////////////////////////////////////////////////////////
  // read data
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata <= 32'h0000_0000;
      // unmapped addresses fall to the default and read as zero
      unique case (addr_ok ? idx : 4'hf)
        dtpb_pkg::IDX_COUNT:    prdata[7:0] <= count_r;
        dtpb_pkg::IDX_CTRL1:    prdata[2:0] <= {ctrl1_r.one_shot,
                                                ctrl1_r.reload,
                                                ctrl1_r.enable};
        dtpb_pkg::IDX_CTRL2:    prdata[5:0] <= ctrl2_r;
        dtpb_pkg::IDX_PSCNT:    prdata[7:0] <= pscnt_r;
        dtpb_pkg::IDX_IRQ_STAT: prdata[0]   <= stat_r;
        dtpb_pkg::IDX_IRQ_EN:   prdata[0]   <= irq_en_r;
        default:                prdata      <= 32'h0000_0000;
      endcase
    end
  end

endmodule

/* design/dtpb_pkg.sv */
package dtpb_pkg;

  // register word indices, byte address is index times 4 (printed offsets are indices)
  localparam logic [3:0] IDX_COUNT    = 4'h0;
  localparam logic [3:0] IDX_CTRL1    = 4'h1;
  localparam logic [3:0] IDX_CTRL2    = 4'h2;
  localparam logic [3:0] IDX_DUTY     = 4'h3;
  localparam logic [3:0] IDX_PSCNT    = 4'h4;
  localparam logic [3:0] IDX_BUZZ     = 4'h5;
  localparam logic [3:0] IDX_IRQ_STAT = 4'h6;
  localparam logic [3:0] IDX_IRQ_CLR  = 4'h7;
  localparam logic [3:0] IDX_IRQ_EN   = 4'h8;

  // timer_control_one fields
  localparam int CTRL1_ENABLE   = 0;
  localparam int CTRL1_RELOAD   = 1;
  localparam int CTRL1_ONE_SHOT = 2;
  localparam int CTRL1_POLARITY = 6;
  localparam int CTRL1_PWM_OE   = 7;

  // timer_control_two fields
  localparam int CTRL2_RATE_LSB = 0;
  localparam int CTRL2_PS_DIS_N = 3;
  localparam int CTRL2_EDGE     = 4;
  localparam int CTRL2_SOURCE   = 5;

  // buzzer_control fields
  localparam int BUZZ_FSEL_LSB = 0;
  localparam int BUZZ_ENABLE   = 7;

  // reset values, underflow wrap value and zero compare
  localparam logic [7:0] RST_COUNT = 8'h00;
  localparam logic [7:0] RST_CTRL1 = 8'h00;
  localparam logic [5:0] RST_CTRL2 = 6'h3f;
  localparam logic [7:0] RST_DUTY  = 8'h00;
  localparam logic [7:0] RST_PSCNT = 8'hff;
  localparam logic [7:0] RST_BUZZ  = 8'h0f;
  localparam logic [7:0] CNT_WRAP  = 8'hff;
  localparam logic [7:0] CNT_ZERO  = 8'h00;

  typedef struct packed {
    logic       pwm_oe;
    logic       polarity;
    logic       one_shot;
    logic       reload;
    logic       enable;
  } dtpb_ctrl1_t;

  typedef struct packed {
    logic       source;
    logic       edge_sel;
    logic       ps_dis_n;
    logic [2:0] rate;
  } dtpb_ctrl2_t;

  // shared pin controls
  typedef struct packed {
    logic o;
    logic oe;
  } dtpb_pin_t;

endpackage

/* tb/dtpb_pin_model.sv */
`timescale 1ns/10ps
module dtpb_pin_model (
  // design side of the pin
  input  wire logic drv,
  input  wire logic drv_en,
  // external clock source on the far side
  input  wire logic clk_on,
  input  wire logic clk_lvl,
  // level seen on the pin
  output logic      level
);
  // pull-up keeps the line high when nobody drives it
  assign level = drv_en ? drv : (clk_on ? clk_lvl : 1'h1);
endmodule

/* tb/dtpb_checker.sv */
`timescale 1ns/10ps
module dtpb_checker (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // pin and interrupt
  input wire logic        gpio_oe,
  input wire logic        shared_pin_oe,
  input wire logic        irq
);
  // shadow of pin claims and irq enable: {ien, buzzer, pwm, ext}
  logic [3:0] cl_r;
  wire        rd_acc = psel && penable && !pwrite;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cl_r <= 4'h1;
    end else if (psel && penable && pwrite && pstrb[0]) begin
      case (paddr)
        12'h004: cl_r[1] <= pwdata[7];
        12'h008: cl_r[0] <= pwdata[5];
        12'h014: cl_r[2] <= pwdata[7];
        12'h020: cl_r[3] <= pwdata[0];
        default: ;
      endcase
    end
  end
////////////////////////////////////////////////////////////
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  a_ready_high: assert property (pready) else $error("pready low");
  a_err_unmapped: assert property (psel && penable && paddr > 12'h020
    |-> pslverr) else $error("no error on unmapped");
  a_err_mapped: assert property (psel && penable && paddr <= 12'h020
    && paddr[1:0] == 2'h0 |-> !pslverr) else $error("error on mapped");
  a_upper_zero: assert property (rd_acc |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_wo_zero: assert property (rd_acc && (paddr == 12'h00c ||
    paddr == 12'h014 || paddr == 12'h01c) |-> prdata == 32'h0)
    else $error("write-only register readable");
  a_ext_input: assert property (cl_r[0] && $past(cl_r[0])
    |-> !shared_pin_oe) else $error("pin driven in external mode");
  a_pwm_drive: assert property (cl_r[1:0] == 2'h2
    && $past(cl_r[1:0]) == 2'h2 |-> shared_pin_oe)
    else $error("pwm not on pin");
  a_buzz_drive: assert property (cl_r[2:0] == 3'h4
    && $past(cl_r[2:0]) == 3'h4 |-> shared_pin_oe)
    else $error("buzzer not on pin");
  a_gpio_pass: assert property (cl_r[2:0] == 3'h0
    && $past(cl_r[2:0]) == 3'h0 |-> shared_pin_oe == $past(gpio_oe))
    else $error("gpio enable not passed");
  a_irq_masked: assert property (!cl_r[3] |-> !irq)
    else $error("irq while disabled");

  c_irq: cover property (irq);
  c_err: cover property (psel && penable && pslverr);
  c_pwm: cover property (shared_pin_oe && cl_r[1]);
endmodule

bind dtpb_timer dtpb_checker i_chk (.*);

/* tb/dtpb_timer_tb.sv */
`timescale 1ns/10ps
`define CHK(a, e) begin \
  comparisons++; \
  if ((a) !== (e)) begin \
    error_cnt++; \
    $display("CHECK FAILED %0t got %h want %h", $time, (a), (e)); \
  end \
end
module dtpb_timer_tb;
  logic        sys_clk = 1'h0;
  logic        sys_rst = 1'h1;
  logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, irq, pin_i, pin_o, pin_oe, ev;
  logic        inst_tick = 1'h0, gpio_o = 1'h0, gpio_oe = 1'h0;
  logic        ext_on = 1'h0, ext_lvl = 1'h0;
  logic [7:0]  rv;
  logic [7:0]  pat = 8'ha5;
  int          error_cnt = 0;
  int          comparisons = 0;
  // reset view of registers 0x000 to 0x020 except 0x01c, then unmapped 0x024: {address, value}
  logic [19:0] rows [9] = '{20'h00000, 20'h00400, 20'h0083f, 20'h00c00,
    20'h010ff, 20'h01400, 20'h01800, 20'h02000, 20'h02400};

  dtpb_timer i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .inst_tick(inst_tick), .shared_pin_i(pin_i), .shared_pin_o(pin_o),
    .shared_pin_oe(pin_oe), .gpio_o(gpio_o), .gpio_oe(gpio_oe), .irq(irq));
  dtpb_pin_model i_pin (.drv(pin_o), .drv_en(pin_oe), .clk_on(ext_on),
    .clk_lvl(ext_lvl), .level(pin_i));

  initial begin
    forever #4 sys_clk = ~sys_clk;
  end
////////////////////////////////////////
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [7:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge sys_clk);
    penable <= 1'h1;
    do @(posedge sys_clk); while (pready !== 1'h1);
    rv = prdata[7:0];
    ev = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    // idle edges let registered outputs settle
    repeat (2) @(posedge sys_clk);
  endtask

  task automatic tk(input int n);
    repeat (n) begin
      inst_tick <= 1'h1;
      @(posedge sys_clk);
      inst_tick <= 1'h0;
      repeat (5) @(posedge sys_clk);
    end
  endtask

  task automatic pin(input logic v);
    ext_lvl <= v;
    repeat (5) @(posedge sys_clk);
  endtask

  task automatic stop_test;
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
////////////////////////////////////////
  initial begin
    repeat (5000) @(posedge sys_clk);
    error_cnt++;
    stop_test();
  end

  initial begin
    repeat (5) @(posedge sys_clk);
    sys_rst <= 1'h0;
    @(posedge sys_clk);
    foreach (rows[i]) begin
      apb(1'h0, rows[i][19:8], 8'h00);
      `CHK(rv, rows[i][7:0])
    end
    `CHK(ev, 1'h1)
    // instruction clock, prescaler off, rate code 0
    apb(1'h1, 12'h008, 8'h08);
    apb(1'h1, 12'h000, 8'h02);
    apb(1'h1, 12'h004, 8'h01);
    tk(3);
    apb(1'h0, 12'h000, 8'h00);
    `CHK(rv, 8'hff)
    apb(1'h0, 12'h018, 8'h00);
    `CHK(rv, 8'h01)
    apb(1'h1, 12'h020, 8'h01);
    `CHK(irq, 1'h1)
    apb(1'h1, 12'h01c, 8'h01);
    `CHK(irq, 1'h0)
    apb(1'h1, 12'h004, 8'h00);
    apb(1'h1, 12'h000, 8'h02);
    apb(1'h1, 12'h004, 8'h03);
    tk(3);
    apb(1'h0, 12'h000, 8'h00);
    `CHK(rv, 8'h02)
    apb(1'h1, 12'h004, 8'h00);
    apb(1'h1, 12'h000, 8'h01);
    apb(1'h1, 12'h004, 8'h05);
    tk(4);
    apb(1'h0, 12'h000, 8'h00);
    `CHK(rv, 8'h00)
    apb(1'h1, 12'h004, 8'h00);
    apb(1'h1, 12'h000, 8'h05);
    tk(2);
    apb(1'h0, 12'h000, 8'h00);
    `CHK(rv, 8'h05)
    ext_on <= 1'h1;
    apb(1'h1, 12'h008, 8'h38);
    apb(1'h1, 12'h004, 8'h01);
    pin(1'h1);
    apb(1'h0, 12'h000, 8'h00);
    `CHK(rv, 8'h05)
    pin(1'h0);
    apb(1'h0, 12'h000, 8'h00);
    `CHK(rv, 8'h04)
    apb(1'h1, 12'h008, 8'h28);
    pin(1'h1);
    apb(1'h0, 12'h000, 8'h00);
    `CHK(rv, 8'h03)
    `CHK(pin_oe, 1'h0)
    ext_on <= 1'h0;
    apb(1'h1, 12'h008, 8'h08);
    apb(1'h1, 12'h004, 8'h00);
    apb(1'h1, 12'h00c, 8'h01);
    apb(1'h0, 12'h00c, 8'h00);
    `CHK(rv, 8'h00)
    apb(1'h1, 12'h000, 8'h03);
    apb(1'h1, 12'h004, 8'h83);
    `CHK(pin_oe, 1'h1)
    `CHK(pin_o, 1'h0)
    tk(2);
    `CHK(pin_o, 1'h1)
    tk(1);
    `CHK(pin_o, 1'h1)
    tk(1);
    `CHK(pin_o, 1'h0)
    apb(1'h1, 12'h004, 8'hc3);
    `CHK(pin_o, 1'h1)
    apb(1'h1, 12'h004, 8'h00);
    apb(1'h1, 12'h000, pat);
    gpio_oe <= 1'h1;
    gpio_o <= 1'h1;
    repeat (3) @(posedge sys_clk);
    `CHK(pin_o, 1'h1)
    for (int k = 0; k < 8; k++) begin
      apb(1'h1, 12'h014, 8'h88 + 8'(k));
      repeat (2) @(posedge sys_clk);
      `CHK(pin_o, pat[k])
    end
    apb(1'h1, 12'h008, 8'h09);
    apb(1'h1, 12'h008, 8'h01);
    apb(1'h1, 12'h000, 8'h05);
    apb(1'h1, 12'h004, 8'h01);
    tk(4);
    apb(1'h0, 12'h000, 8'h00);
    `CHK(rv, 8'h04)
    apb(1'h0, 12'h010, 8'h00);
    `CHK(rv, 8'hfb)
    apb(1'h1, 12'h014, 8'h80);
    `CHK(pin_o, 1'h1)
    apb(1'h1, 12'h014, 8'h08);
    gpio_oe <= 1'h0;
    repeat (3) @(posedge sys_clk);
    `CHK(pin_oe, 1'h0)
    stop_test();
  end
endmodule
